// ===== pcg_top.v
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - set gate bit stops peripheral clock, freezes state, blocks register access
// - clearing gate bit restarts clock, module resumes frozen state
// - gating acts in active and idle, and for the converter bit also in noise reduction; deeper sleep stops the clocks anyway
// - bit 7 gates pwm stage controller 2; reinitialise after ungating
// - bit 6 gates pwm stage controller 1; reinitialise after ungating
// - bit 5 gates pwm stage controller 0; reinitialise after ungating
// - bit 4 gates 16-bit timer; resumes as before when ungated
// - bit 3 gates 8-bit timer; resumes as before when ungated
// - bit 2 gates serial peripheral interface; reinitialise after ungating
// - comparator cannot use converter mux while converter clock gated
// - enabled converter stays enabled in sleep; restart gives extended conversion
// - comparator auto-off outside idle and noise reduction; its reference stays
// - reference on only while brownout, comparator or converter need it
// - brownout enabled by level fuse stays active in every sleep mode
// - enabled watchdog keeps running in every sleep mode
// - input buffers off when io and converter clocks stop, except wake pins in input_buf_en_0_o
// - input-disable register bits turn off pin digital input buffers
// - debug fuse programmed keeps main clock source running in sleep
// - sleep select 000 idle, 001 noise reduction, 010 power-down
// - power-down halts all generated clocks, only async modules run
`include "pcg_map.vh"

module pcg_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // system state from core and fuses
  input  wire        sleeping_i,
  input  wire        debug_enable_fuse_i,
  input  wire        brownout_level_fuse_i,
  input  wire [7:0]  wake_pin_mask_i,
  // clock enables to peripherals, order stage2..converter as gate bits
  output reg  [7:0]  periph_clk_en_o,
  output reg  [7:0]  periph_access_en_o,
  output reg         cpu_clk_en_o,
  output reg         io_clk_en_o,
  output reg         adc_clk_en_o,
  output reg         pll_clk_en_o,
  output reg         main_osc_en_o,
  // analog and support enables
  output reg         adc_en_o,
  output reg         adc_extended_conv_o,
  output reg         acmp_en_o,
  output reg         acmp_mux_en_o,
  output reg         vref_en_o,
  output reg         brownout_en_o,
  output reg         wdt_en_o,
  // digital input buffer enables per pin
  output reg  [7:0]  input_buf_en_0_o,
  output reg  [7:0]  input_buf_en_1_o
);

  // ========================================================================
  // registers
  reg  [7:0]  peripheral_clock_gate;
  reg  [3:0]  sleep_ctrl;
  reg  [4:0]  analog_ctrl;
  reg  [7:0]  input_disable_0;
  reg  [7:0]  input_disable_1;
  reg         adc_was_off;
  reg  [7:0]  next_gate;

  wire [2:0]  sleep_mode_select = sleep_ctrl[3:1];
  wire        sleep_enable      = sleep_ctrl[0];
  wire        wr_acc  = psel_i & penable_i & pwrite_i & pready_o;
  wire        rd_acc  = psel_i & penable_i & ~pwrite_i & pready_o;

  // ========================================================================
  // apb slave: one wait state, access phase answered on its second cycle
  wire        setup  = psel_i & ~penable_i;
  wire        hit = (paddr_i == `PCG_OFF_GATE)   |
                    (paddr_i == `PCG_OFF_SLEEP)  |
                    (paddr_i == `PCG_OFF_ANALOG) |
                    (paddr_i == `PCG_OFF_INDIS0) |
                    (paddr_i == `PCG_OFF_INDIS1) |
                    (paddr_i == `PCG_OFF_STATUS);

  always @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
    end
  end

  always @* begin
    next_gate = peripheral_clock_gate;
    if (wr_acc && paddr_i == `PCG_OFF_GATE) begin
      // reserved bit 1 ignores writes and reads zero
      next_gate = pwdata_i[7:0] & `PCG_GATE_WMASK;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_clock_gate <= `PCG_GATE_RESET;
      sleep_ctrl            <= `PCG_SLEEP_RESET;
      analog_ctrl           <= `PCG_ANALOG_RESET;
      input_disable_0       <= 8'h00;
      input_disable_1       <= 8'h00;
    end else begin
      peripheral_clock_gate <= next_gate;
      if (wr_acc && paddr_i == `PCG_OFF_SLEEP)
        sleep_ctrl <= pwdata_i[3:0];
      if (wr_acc && paddr_i == `PCG_OFF_ANALOG)
        analog_ctrl <= pwdata_i[4:0];
      if (wr_acc && paddr_i == `PCG_OFF_INDIS0)
        input_disable_0 <= pwdata_i[7:0];
      if (wr_acc && paddr_i == `PCG_OFF_INDIS1)
        input_disable_1 <= pwdata_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i & penable_i & ~pready_o) begin
      case (paddr_i)
        `PCG_OFF_GATE:   prdata_o <= {24'h000000, peripheral_clock_gate};
        `PCG_OFF_SLEEP:  prdata_o <= {28'h0000000, sleep_ctrl};
        `PCG_OFF_ANALOG: prdata_o <= {27'h0000000, analog_ctrl};
        `PCG_OFF_INDIS0: prdata_o <= {24'h000000, input_disable_0};
        `PCG_OFF_INDIS1: prdata_o <= {24'h000000, input_disable_1};
        `PCG_OFF_STATUS: prdata_o <= {24'h000000, vref_en_o, acmp_en_o,
                                      adc_en_o, adc_extended_conv_o,
                                      io_clk_en_o, adc_clk_en_o,
                                      main_osc_en_o, cpu_clk_en_o};
        default:         prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // sleep mode decode
  wire in_sleep = sleeping_i & sleep_enable;
  wire m_idle   = in_sleep & (sleep_mode_select == `PCG_SM_IDLE);
  wire m_noise  = in_sleep & (sleep_mode_select == `PCG_SM_NOISE);
  wire m_stdby  = in_sleep & (sleep_mode_select == `PCG_SM_STDBY);
  // reserved codes are treated like power-down, the safest choice
  wire m_deep   = in_sleep & ~m_idle & ~m_noise;

  wire io_run   = ~in_sleep | m_idle;
  wire adc_run  = ~in_sleep | m_idle | m_noise;
  wire osc_run  = ~m_deep | m_stdby | debug_enable_fuse_i;

  wire acmp_on  = analog_ctrl[`PCG_AN_ACMP_EN] & (~m_deep);
  wire adc_on   = analog_ctrl[`PCG_AN_ADC_EN];
  // comparator wired to the reference keeps it on in any sleep
  wire acmp_ref = analog_ctrl[`PCG_AN_ACMP_EN] &
                  analog_ctrl[`PCG_AN_ACMP_REF];

  // ========================================================================
  // outputs, all registered; enables change one edge after the gate
  // register so the downstream latch-based clock gates see clean levels
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_gate
      always @(posedge clk_i) begin
        if (rst_i) begin
          periph_clk_en_o[g]    <= 1'b1;
          periph_access_en_o[g] <= 1'b1;
        end else begin
          // gating only matters while the io clock (converter clock for bit 0) runs; deeper sleep stops it
          periph_clk_en_o[g]    <= ~peripheral_clock_gate[g] &
                                   (g == `PCG_BIT_ADC ? adc_run : io_run);
          periph_access_en_o[g] <= ~peripheral_clock_gate[g];
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o        <= 1'b1;
      io_clk_en_o         <= 1'b1;
      adc_clk_en_o        <= 1'b1;
      pll_clk_en_o        <= 1'b1;
      main_osc_en_o       <= 1'b1;
      adc_en_o            <= 1'b0;
      adc_extended_conv_o <= 1'b0;
      adc_was_off         <= 1'b1;
      acmp_en_o           <= 1'b0;
      acmp_mux_en_o       <= 1'b0;
      vref_en_o           <= 1'b0;
      brownout_en_o       <= 1'b0;
      wdt_en_o            <= 1'b0;
      input_buf_en_0_o    <= 8'hff;
      input_buf_en_1_o    <= 8'hff;
    end else begin
      cpu_clk_en_o  <= ~in_sleep;
      io_clk_en_o   <= io_run;
      adc_clk_en_o  <= adc_run & ~peripheral_clock_gate[`PCG_BIT_ADC];
      pll_clk_en_o  <= adc_run;
      main_osc_en_o <= osc_run;
      adc_en_o      <= adc_on;
      // first conversion after an off/on cycle is the extended one
      if (!adc_on)
        adc_was_off <= 1'b1;
      else
        adc_was_off <= 1'b0;
      adc_extended_conv_o <= adc_on & adc_was_off;
      acmp_en_o     <= acmp_on;
      acmp_mux_en_o <= acmp_on & analog_ctrl[`PCG_AN_ACMP_MUX] &
                       ~peripheral_clock_gate[`PCG_BIT_ADC];
      vref_en_o     <= brownout_level_fuse_i | acmp_ref | acmp_on |
                       adc_on;
      brownout_en_o <= brownout_level_fuse_i;
      wdt_en_o      <= analog_ctrl[`PCG_AN_WDT_EN];
      // buffers off in deep sleep except wake pins of input_buf_en_0_o, and always where
      // software disabled them
      input_buf_en_0_o <= ~input_disable_0 &
                          ((io_run | adc_run) ? 8'hff : wake_pin_mask_i);
      input_buf_en_1_o <= ~input_disable_1 &
                          ((io_run | adc_run) ? 8'hff : 8'h00);
    end
  end

endmodule // pcg_top

// ===== pcg_map.vh
`ifndef PCG_MAP_VH
`define PCG_MAP_VH
// ==========================================================================
// register byte offsets
`define PCG_OFF_GATE      12'h000
`define PCG_OFF_SLEEP     12'h004
`define PCG_OFF_ANALOG    12'h008
`define PCG_OFF_INDIS0    12'h00c
`define PCG_OFF_INDIS1    12'h010
`define PCG_OFF_STATUS    12'h014
// ==========================================================================
// gate register fields
`define PCG_BIT_ADC       0
`define PCG_BIT_RSVD      1
`define PCG_BIT_SPI       2
`define PCG_BIT_TIM8      3
`define PCG_BIT_TIM16     4
`define PCG_BIT_PWM0      5
`define PCG_BIT_PWM1      6
`define PCG_BIT_PWM2      7
`define PCG_GATE_WMASK    8'hfd
`define PCG_GATE_RESET    8'h00
// ==========================================================================
// sleep control fields
`define PCG_SM_IDLE       3'h0
`define PCG_SM_NOISE      3'h1
`define PCG_SM_PDOWN      3'h2
`define PCG_SM_STDBY      3'h6
`define PCG_SLEEP_RESET   4'h0
// ==========================================================================
// analog control fields
`define PCG_AN_ADC_EN     0
`define PCG_AN_ACMP_EN    1
`define PCG_AN_ACMP_REF   2
`define PCG_AN_ACMP_MUX   3
`define PCG_AN_WDT_EN     4
`define PCG_ANALOG_RESET  5'h00
`endif

// ===== pcg_top_monitor.sv
`timescale 1ns/1ps
`include "pcg_map.vh"
// ==========================================================
// checker on the top ports
module pcg_chk (
  // clock, reset, bus
  input logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i,
  // system state and enables
  input logic        sleeping_i, debug_enable_fuse_i, brownout_level_fuse_i,
  input logic        main_osc_en_o, acmp_mux_en_o, vref_en_o, brownout_en_o,
  input logic        adc_en_o,
  input logic [7:0]  periph_clk_en_o, periph_access_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_gate;
  assign wr_gate = psel_i && penable_i && pready_o && pwrite_i
                   && paddr_i == `PCG_OFF_GATE;
  property p_gate_stops;
    (periph_clk_en_o & ~periph_access_en_o & 8'hfd) == 8'h00;
  endproperty
  a_gate_stops: assert property (p_gate_stops)
    else $error("gated peripheral clock still running");
  // bit 1 masked: it has no peripheral and follows the io clock
  property p_gate_write;
    wr_gate ##1 !sleeping_i |=> ((periph_clk_en_o & 8'hfd)
      == (~$past(pwdata_i[7:0], 2) & 8'hfd));
  endproperty
  a_gate_write: assert property (p_gate_write)
    else $error("clock enables do not follow gate write");
  property p_reset;
    $fell(rst_i) |-> periph_clk_en_o == 8'hff && periph_access_en_o == 8'hff;
  endproperty
  a_reset: assert property (p_reset)
    else $error("enables not all on after reset");
  property p_active;
    (!sleeping_i && $stable(periph_access_en_o)) [*3] |->
      (periph_clk_en_o & 8'hfd) == (periph_access_en_o & 8'hfd);
  endproperty
  a_active: assert property (p_active)
    else $error("active clock enables differ from gate bits");
  property p_mux;
    (!periph_access_en_o[0]) [*3] |-> !acmp_mux_en_o;
  endproperty
  a_mux: assert property (p_mux)
    else $error("comparator uses mux while converter gated");
  property p_vref;
    (brownout_en_o || adc_en_o) [*2] |-> vref_en_o;
  endproperty
  a_vref: assert property (p_vref)
    else $error("reference off while needed");
  property p_bod;
    brownout_level_fuse_i [*3] |-> brownout_en_o;
  endproperty
  a_bod: assert property (p_bod)
    else $error("brownout detector off with fuse set");
  property p_dbg;
    debug_enable_fuse_i [*3] |-> main_osc_en_o;
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("main oscillator stopped with debug fuse");
  property p_ready;
    psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o ##1 !pready_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus answer not after one wait state");
  c_gate: cover property (wr_gate);
  c_dbg: cover property (sleeping_i && debug_enable_fuse_i);
  c_mux: cover property (!periph_access_en_o[0] && !acmp_mux_en_o);
endmodule // pcg_chk
bind pcg_top pcg_chk i_chk (.*);

// ===== pcg_periph_model.sv
`timescale 1ns/1ps
// ==========================================================
// gated peripherals: one free counter each, frozen while gated
module pcg_periph_model (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic [7:0]  periph_clk_en_i,
  output logic [63:0] state_o
);
  always @(posedge clk_i) begin
    for (int n = 0; n < 8; n++) begin
      if (rst_i) state_o[8*n +: 8] <= 8'h00;
      else if (periph_clk_en_i[n])
        state_o[8*n +: 8] <= state_o[8*n +: 8] + 8'h01;
    end
  end
endmodule // pcg_periph_model

// ===== peripheral_clock_gating_bench.sv
`timescale 1ns/1ps
`include "pcg_map.vh"
module peripheral_clock_gating_bench;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, sleeping_i;
  logic        debug_enable_fuse_i, brownout_level_fuse_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [7:0]  wake_pin_mask_i, snap, r;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, cpu_clk_en_o, io_clk_en_o, adc_clk_en_o;
  wire         main_osc_en_o, acmp_mux_en_o, brownout_en_o, wdt_en_o;
  wire         vref_en_o, adc_en_o, pll_clk_en_o;
  wire  [7:0]  input_buf_en_1_o;
  wire  [7:0]  periph_clk_en_o, periph_access_en_o, input_buf_en_0_o;
  wire  [63:0] state;
  logic [32:0] expq[$];
  logic [3:0]  modes [3] = '{4'b0111, 4'b0011, 4'b0000};
  int          mismatches, compares, n;
  pcg_top i_dut (.*, .adc_extended_conv_o(), .acmp_en_o());
  pcg_periph_model i_periph (.clk_i(clk_i), .rst_i(rst_i),
                             .periph_clk_en_i(periph_clk_en_o), .state_o(state));
  // ==========================================================
  // tasks
  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // the master never assumes a latency; the bound only catches a hang
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [32:0] e);
    @(posedge clk_i);
    if (!wr) expq.push_back(e);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr;
    paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask
  task settle;
    repeat (3) @(posedge clk_i);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // read results against queued notes
  always @(posedge clk_i)
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
      chk("read", expq.pop_front(), {pslverr_o, prdata_o});
  initial begin clk_i = 1'b0; forever #5 clk_i = ~clk_i; end
  initial begin #200000; mismatches++; stop_test; end
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i, sleeping_i} = 5'b10000;
    {debug_enable_fuse_i, brownout_level_fuse_i} = 2'b00;
    paddr_i = 12'h000; pwdata_i = 32'h0; wake_pin_mask_i = 8'h00;
    void'($urandom(32'h05bb));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, `PCG_OFF_GATE, 0, 33'h0);
    apb(1'b0, 12'h0f0, 0, {1'b1, 32'h0});
    chk("clk_en", 33'h0ff, periph_clk_en_o);
    for (int b = 0; b < 8; b++) if (b != 1) begin
      apb(1'b1, `PCG_OFF_GATE, 32'h1 << b, 0);
      apb(1'b0, `PCG_OFF_GATE, 0, 33'h1 << b);
      settle; snap = state[8*b +: 8]; settle;
      chk("frozen", snap, state[8*b +: 8]);
      chk("access", 8'(~(8'h1 << b)), periph_access_en_o);
      chk("clk_en", 8'(~(8'h1 << b)), periph_clk_en_o);
      apb(1'b1, `PCG_OFF_GATE, 0, 0); settle;
      chk("resumed", 1'b1, state[8*b +: 8] != snap);
    end
    r = $urandom;
    apb(1'b1, `PCG_OFF_GATE, {24'h0, r}, 0);
    apb(1'b0, `PCG_OFF_GATE, 0, {25'h0, r & 8'hfd});
    settle; chk("rnd_clk", 8'(~r | 8'h02), periph_clk_en_o);
    // converter clock must run before the comparator may take the mux
    apb(1'b1, `PCG_OFF_GATE, 0, 0);
    apb(1'b1, `PCG_OFF_ANALOG, 32'h0a, 0); settle;
    chk("mux_on", 1'b1, acmp_mux_en_o);
    apb(1'b1, `PCG_OFF_GATE, 32'h01, 0); settle;
    chk("mux_off", 1'b0, acmp_mux_en_o);
    apb(1'b1, `PCG_OFF_GATE, 0, 0);
    apb(1'b1, `PCG_OFF_ANALOG, 32'h10, 0);
    r = $urandom;
    apb(1'b1, `PCG_OFF_INDIS0, {24'h0, r}, 0); settle;
    chk("inbuf", 8'(~r), input_buf_en_0_o);
    apb(1'b1, `PCG_OFF_INDIS0, 0, 0);
    brownout_level_fuse_i <= 1'b1;
    wake_pin_mask_i <= 8'($urandom);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `PCG_OFF_SLEEP, {28'h0, 3'(m), 1'b1}, 0);
      sleeping_i <= 1'b1; settle;
      chk("clocks", modes[m], {cpu_clk_en_o, io_clk_en_o,
          adc_clk_en_o, main_osc_en_o});
      chk("support", 2'b11, {brownout_en_o, wdt_en_o});
      chk("pll", modes[m][1], pll_clk_en_o);
      chk("vref", 1'b1, vref_en_o);
      if (m == 2) chk("buf1", 8'h00, input_buf_en_1_o);
      if (m == 2) chk("wake_buf", wake_pin_mask_i, input_buf_en_0_o);
      sleeping_i <= 1'b0; settle;
    end
    debug_enable_fuse_i <= 1'b1; sleeping_i <= 1'b1; settle;
    chk("osc", 1'b1, main_osc_en_o);
    sleeping_i <= 1'b0;
    apb(1'b1, `PCG_OFF_GATE, 32'hf0, 0);
    rst_i <= 1'b1; settle; rst_i <= 1'b0;
    apb(1'b0, `PCG_OFF_GATE, 0, 33'h0);
    settle;
    stop_test;
  end
endmodule // peripheral_clock_gating_bench
